// File: core/tsm_cfg.svh
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH

`define TSM_MODE_W 4
`define TSM_MODE_8LANE 4'h0
`define TSM_MODE_6LANE 4'h1
`define TSM_PART_SINGLE 2'h0
`define TSM_PART_DUAL 2'h1
`define TSM_PART_QUAD 2'h2
`define TSM_SAMP_W 9
`define TSM_PAD_W 3
`define TSM_SLOTS 10
`define TSM_CH_W 90
`define TSM_LANES 8
`define TSM_LANE_W 64
`define TSM_FIFO_DEPTH 4
`define TSM_EN8_SINGLE 8'h03
`define TSM_EN8_DUAL 8'h0F
`define TSM_EN8_QUAD 8'hFF
`define TSM_EN6_SINGLE 8'h03
`define TSM_EN6_DUAL 8'h07
`define TSM_EN6_QUAD 8'h3F
`define TSM_EN_NONE 8'h00

`endif

// File: core/tsm_pkg.sv
package tsm_pkg;
  typedef enum logic [1:0] {
    FMT_8LANE,
    FMT_6LANE,
    FMT_NONE
  } tsm_fmt_t;

  typedef enum logic {
    OUT_EMPTY,
    OUT_FULL
  } tsm_ostate_t;
endpackage

// File: core/tsm_fifo.sv
`timescale 1ns/1ps
module tsm_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
  localparam logic [AW-1:0] LAST_C = AW'(D - 1);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i & ce_i;

  // a frozen fifo refuses writes so no word is silently lost
  assign in_ready_o = (cnt_q != DEPTH_C) & ce_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: core/tsm_pair_pack.sv
`timescale 1ns/1ps
`include "tsm_cfg.svh"
module tsm_pair_pack (
  input wire logic six_lane_i,
  input wire logic y_en_i,
  input wire logic [`TSM_CH_W-1:0] x_i,
  input wire logic [`TSM_CH_W-1:0] y_i,
  output logic [4*`TSM_LANE_W-1:0] lanes_o
);
  localparam int SW = `TSM_SAMP_W;
  localparam int LW = `TSM_LANE_W;

  wire [`TSM_CH_W-1:0] y_m = y_en_i ? y_i : '0;
  wire [SW-1:0] x0 = x_i[0 +: SW];
  wire [SW-1:0] x1 = x_i[SW +: SW];
  wire [SW-1:0] y0 = y_m[0 +: SW];
  wire [SW-1:0] y1 = y_m[SW +: SW];
  logic [4*LW-1:0] e8;
  logic [4*LW-1:0] e6;

  // eight-lane format: five msb-first 12-bit fields then a zero tail nibble
  for (genvar k = 0; k < 4; k++) begin : g_lane
    for (genvar j = 0; j < 5; j++) begin : g_fld
      localparam int SLOT = 2*j + (k % 2);
      assign e8[k*LW + LW-1-12*j -: 12] = (k < 2) ? {x_i[SLOT*SW +: SW], 3'b000} : {y_m[SLOT*SW +: SW], 3'b000};
    end
    assign e8[k*LW +: 4] = 4'h0;
  end

  // six-lane format: samples split across lane boundaries, unused low octets stay zero
  assign e6[0*LW +: LW] = {x0, 3'b000, x1[8:5], 48'h0};
  assign e6[1*LW +: LW] = {x1[4:0], 3'b000, y0[8:1], 48'h0};
  assign e6[2*LW +: LW] = {y0[0], 3'b000, y1, 3'b000, 48'h0};
  assign e6[3*LW +: LW] = '0;

  assign lanes_o = six_lane_i ? e6 : e8;
endmodule

// File: core/tsm_mapper.sv
`timescale 1ns/1ps
`include "tsm_cfg.svh"
// Overview of operation
// - packing follows the selected link mode
// - tail bits always driven zero
// - samples sent most significant bit first
// - same layout repeats each frame, next samples
// - eight-lane: five padded fields plus tail nibble
// - eight-lane: even/odd samples on lane pairs
// - six-lane: A0 padded, A1 split lanes 0-1
// - lane 1 octet two: B0 high or 0x00
// - lane 2: B0 bit0, then B1, dual/quad
// - nine-bit sample sits in field's top bits
// - lowest lanes used, higher ones powered down
module tsm_mapper (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [`TSM_MODE_W-1:0] link_mode_select_i,
  input wire logic [1:0] part_cfg_i,
  input wire logic samp_valid_i,
  output logic samp_ready_o,
  input wire logic [`TSM_CH_W-1:0] samp_a_i,
  input wire logic [`TSM_CH_W-1:0] samp_b_i,
  input wire logic [`TSM_CH_W-1:0] samp_c_i,
  input wire logic [`TSM_CH_W-1:0] samp_d_i,
  output logic lane_valid_o,
  input wire logic lane_ready_i,
  output logic [`TSM_LANE_W-1:0] lane_0_o,
  output logic [`TSM_LANE_W-1:0] lane_1_o,
  output logic [`TSM_LANE_W-1:0] lane_2_o,
  output logic [`TSM_LANE_W-1:0] lane_3_o,
  output logic [`TSM_LANE_W-1:0] lane_4_o,
  output logic [`TSM_LANE_W-1:0] lane_5_o,
  output logic [`TSM_LANE_W-1:0] lane_6_o,
  output logic [`TSM_LANE_W-1:0] lane_7_o,
  output logic [`TSM_LANES-1:0] lane_en_o,
  output logic mode_err_o
);
  localparam int CW = `TSM_CH_W;
  localparam int LW = `TSM_LANE_W;
  localparam int FW = 4 * `TSM_CH_W;

  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // mode and part straps are pins: two flops before use
  logic [`TSM_MODE_W-1:0] mode_s1_q;
  logic [`TSM_MODE_W-1:0] mode_s2_q;
  logic [1:0] part_s1_q;
  logic [1:0] part_s2_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_q <= `TSM_MODE_8LANE;
      mode_s2_q <= `TSM_MODE_8LANE;
      part_s1_q <= `TSM_PART_SINGLE;
      part_s2_q <= `TSM_PART_SINGLE;
    end else if (ce_i) begin
      mode_s1_q <= link_mode_select_i;
      mode_s2_q <= mode_s1_q;
      part_s1_q <= part_cfg_i;
      part_s2_q <= part_s1_q;
    end
  end

  wire is_quad = (part_s2_q == `TSM_PART_QUAD);
  wire is_dual = (part_s2_q == `TSM_PART_DUAL);
  wire is_single = !is_quad && !is_dual;
  tsm_pkg::tsm_fmt_t fmt_d;
  assign fmt_d = (mode_s2_q == `TSM_MODE_8LANE) ? tsm_pkg::FMT_8LANE :
                 (mode_s2_q == `TSM_MODE_6LANE) ? tsm_pkg::FMT_6LANE : tsm_pkg::FMT_NONE;
  wire six = (fmt_d == tsm_pkg::FMT_6LANE);

  wire [`TSM_LANES-1:0] en8 = is_quad ? `TSM_EN8_QUAD : is_dual ? `TSM_EN8_DUAL : `TSM_EN8_SINGLE;
  wire [`TSM_LANES-1:0] en6 = is_quad ? `TSM_EN6_QUAD : is_dual ? `TSM_EN6_DUAL : `TSM_EN6_SINGLE;
  wire [`TSM_LANES-1:0] en_d = (fmt_d == tsm_pkg::FMT_8LANE) ? en8 :
                               six ? en6 : `TSM_EN_NONE;

  // four whole frames of samples buffered ahead of the packer
  logic [FW-1:0] fd;
  logic f_valid;
  logic ld;

  tsm_fifo #(
    .W(FW),
    .D(`TSM_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .ce_i(ce_i),
    .in_valid_i(samp_valid_i),
    .in_ready_o(samp_ready_o),
    .in_data_i({samp_d_i, samp_c_i, samp_b_i, samp_a_i}),
    .out_valid_o(f_valid),
    .out_ready_i(ld),
    .out_data_o(fd)
  );

  wire [CW-1:0] fa = fd[0*CW +: CW];
  wire [CW-1:0] fb = fd[1*CW +: CW];
  wire [CW-1:0] fc = fd[2*CW +: CW];
  wire [CW-1:0] fdd = fd[3*CW +: CW];

  logic [4*LW-1:0] p0;
  logic [4*LW-1:0] p1;

  tsm_pair_pack u_pack_ab (
    .six_lane_i(six),
    .y_en_i(!is_single),
    .x_i(fa),
    .y_i(fb),
    .lanes_o(p0)
  );

  // channels C and D only exist on the quad part
  tsm_pair_pack u_pack_cd (
    .six_lane_i(six),
    .y_en_i(is_quad),
    .x_i(is_quad ? fc : '0),
    .y_i(fdd),
    .lanes_o(p1)
  );

  logic [`TSM_LANES-1:0][LW-1:0] map_w;
  assign map_w[0] = p0[0*LW +: LW];
  assign map_w[1] = p0[1*LW +: LW];
  assign map_w[2] = p0[2*LW +: LW];
  assign map_w[3] = six ? p1[0*LW +: LW] : p0[3*LW +: LW];
  assign map_w[4] = six ? p1[1*LW +: LW] : p1[0*LW +: LW];
  assign map_w[5] = six ? p1[2*LW +: LW] : p1[1*LW +: LW];
  assign map_w[6] = six ? '0 : p1[2*LW +: LW];
  assign map_w[7] = six ? '0 : p1[3*LW +: LW];

  logic [`TSM_LANES-1:0][LW-1:0] lane_d;
  for (genvar k = 0; k < `TSM_LANES; k++) begin : g_mask
    assign lane_d[k] = en_d[k] ? map_w[k] : '0;
  end

  // one output frame register; a stalled receiver backs up into the fifo
  tsm_pkg::tsm_ostate_t ost_q;
  tsm_pkg::tsm_ostate_t ost_d;
  logic [`TSM_LANES-1:0][LW-1:0] lane_q;
  logic [`TSM_LANES-1:0] lane_en_q;
  logic mode_err_q;

  assign lane_valid_o = (ost_q == tsm_pkg::OUT_FULL);
  assign ld = f_valid & ce_i & (!lane_valid_o | lane_ready_i);

  always_comb begin
    ost_d = ost_q;
    unique case (ost_q)
      tsm_pkg::OUT_EMPTY: begin
        if (ld && fmt_d != tsm_pkg::FMT_NONE) begin
          ost_d = tsm_pkg::OUT_FULL;
        end
      end
      tsm_pkg::OUT_FULL: begin
        if (ce_i && lane_ready_i && !(ld && fmt_d != tsm_pkg::FMT_NONE)) begin
          ost_d = tsm_pkg::OUT_EMPTY;
        end
      end
    endcase
  end

  // frames taken under an unsupported mode are drained and dropped
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ost_q <= tsm_pkg::OUT_EMPTY;
      lane_q <= '0;
      lane_en_q <= `TSM_EN_NONE;
      mode_err_q <= 1'b0;
    end else if (ce_i) begin
      ost_q <= ost_d;
      mode_err_q <= (fmt_d == tsm_pkg::FMT_NONE);
      if (ld) begin
        lane_q <= lane_d;
        lane_en_q <= en_d;
      end
    end
  end

  assign lane_0_o = lane_q[0];
  assign lane_1_o = lane_q[1];
  assign lane_2_o = lane_q[2];
  assign lane_3_o = lane_q[3];
  assign lane_4_o = lane_q[4];
  assign lane_5_o = lane_q[5];
  assign lane_6_o = lane_q[6];
  assign lane_7_o = lane_q[7];
  assign lane_en_o = lane_en_q;
  assign mode_err_o = mode_err_q;

  logic [`TSM_LANES-1:0] tail_nz;
  for (genvar k = 0; k < `TSM_LANES; k++) begin : g_tail
    assign tail_nz[k] = |lane_q[k][3:0];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence load8_s;
    ld && ce_i && fmt_d == tsm_pkg::FMT_8LANE;
  endsequence

  sequence load6_s;
    ld && ce_i && fmt_d == tsm_pkg::FMT_6LANE;
  endsequence

  sequence take_s;
    lane_valid_o && lane_ready_i && ce_i;
  endsequence

  sequence drop_s;
    ld && ce_i && fmt_d == tsm_pkg::FMT_NONE;
  endsequence

  // lanes outside the enable mask must stay quiet, they are powered down
  logic [`TSM_LANES-1:0] off_nz;
  for (genvar k = 0; k < `TSM_LANES; k++) begin : g_off
    assign off_nz[k] = !lane_en_q[k] && (|lane_q[k]);
  end

  mode_lanes_a: assert property (load6_s |=> lane_en_o[7:6] == 2'b00 && lane_q[0][47:0] == '0)
    else $error("six-lane frame touches unused lanes or octets");
  tail_zero_a: assert property (lane_valid_o |-> tail_nz == '0)
    else $error("tail nibble not zero");
  msb_first_a: assert property (load8_s |=> lane_q[0][63:55] == $past(fa[8:0]))
    else $error("first sample not in top bits of lane 0");
  frame_next_a: assert property ((ld && ce_i && fmt_d != tsm_pkg::FMT_NONE) |=> lane_valid_o)
    else $error("loaded frame not presented");
  field_pad_a: assert property (load8_s |=> lane_q[0][54:52] == 3'b000 && lane_q[1][42:40] == 3'b000)
    else $error("field padding not zero");
  lane_odd_a: assert property (load8_s |=> lane_q[1][63:55] == $past(fa[17:9])
                               && lane_q[0][51:43] == $past(fa[26:18]))
    else $error("even/odd sample split wrong");
  six_split_a: assert property (load6_s |=> lane_q[0][63:52] == {$past(fa[8:0]), 3'b000}
                                && lane_q[1][63:59] == $past(fa[13:9]))
    else $error("sample A1 split wrong");
  fill_byte_a: assert property ((load6_s and is_single) |=> lane_q[1][55:48] == 8'h00)
    else $error("fill octet not zero on single part");
  lane_two_a: assert property ((load6_s and !is_single) |=> lane_q[2][63:60] == {$past(fb[0]), 3'b000}
                               && lane_q[2][59:51] == $past(fb[17:9]))
    else $error("lane 2 content wrong");
  quad_rep_a: assert property ((load6_s and is_quad) |=> lane_q[3][63:55] == $past(fc[8:0])
                               && lane_q[5][59:51] == $past(fdd[17:9]))
    else $error("quad lanes 3 to 5 wrong");
  low_lanes_a: assert property ((8'(lane_en_o + 8'h01) & lane_en_o) == 8'h00)
    else $error("enabled lanes not contiguous from lane 0");
  hold_out_a: assert property (lane_valid_o && !lane_ready_i && ce_i |=> $stable(lane_q) && lane_valid_o)
    else $error("frame changed while stalled");

  pair_b8_a: assert property ((load8_s and !is_single) |=> lane_q[2][63:55] == $past(fb[8:0])
                              && lane_q[3][63:55] == $past(fb[17:9]))
    else $error("channel B lane pair wrong");
  quad_d8_a: assert property ((load8_s and is_quad) |=> lane_q[6][63:55] == $past(fdd[8:0])
                              && lane_q[7][15:7] == $past(fdd[89:81]))
    else $error("channel D lane pair wrong");
  last_field_a: assert property (load8_s |=> lane_q[0][15:7] == $past(fa[80:72])
                                 && lane_q[1][15:7] == $past(fa[89:81]))
    else $error("last field of lane pair wrong");
  tail_pad_a: assert property (load8_s |=> lane_q[0][6:4] == 3'b000 && lane_q[1][6:4] == 3'b000)
    else $error("last field padding not zero");
  lane_two_pad_a: assert property ((load6_s and !is_single) |=> lane_q[2][50:48] == 3'b000
                                   && lane_q[2][47:0] == '0)
    else $error("lane 2 padding not zero");
  quad_mid_a: assert property ((load6_s and is_quad) |=> lane_q[4][63:59] == $past(fc[13:9])
                               && lane_q[4][55:48] == $past(fdd[8:1]))
    else $error("quad lane 4 wrong");
  b_high_a: assert property ((load6_s and !is_single) |=> lane_q[1][55:48] == $past(fb[8:1]))
    else $error("channel B high bits wrong");
  off_quiet_a: assert property (lane_valid_o |-> off_nz == '0)
    else $error("disabled lane carries data");
  en8_quad_a: assert property ((load8_s and is_quad) |=> lane_en_o == `TSM_EN8_QUAD)
    else $error("quad eight-lane mask wrong");
  en8_dual_a: assert property ((load8_s and is_dual) |=> lane_en_o == `TSM_EN8_DUAL)
    else $error("dual eight-lane mask wrong");
  en6_dual_a: assert property ((load6_s and is_dual) |=> lane_en_o == `TSM_EN6_DUAL)
    else $error("dual six-lane mask wrong");
  en6_quad_a: assert property ((load6_s and is_quad) |=> lane_en_o == `TSM_EN6_QUAD)
    else $error("quad six-lane mask wrong");
  lane_low_on_a: assert property ((load8_s or load6_s) |=> lane_en_o[1:0] == 2'b11)
    else $error("lowest lanes not enabled");

  // a dropped frame must not leave stale lanes presented to the receiver
  drop_bad_a: assert property ((drop_s and !lane_valid_o) |=> !lane_valid_o)
    else $error("frame under unsupported mode presented");
  err_flag_a: assert property (drop_s |=> mode_err_o)
    else $error("mode error flag not raised");
  drain_end_a: assert property ((take_s and !f_valid) |=> !lane_valid_o)
    else $error("valid held with no frame behind it");
  freeze_a: assert property (!ce_i |=> $stable(lane_q) && $stable(ost_q) && $stable(lane_en_q))
    else $error("state moved while clock enable low");
  refuse_ce_a: assert property (!ce_i |-> !samp_ready_o)
    else $error("samples accepted while frozen");
endmodule

// File: tb/tsm_rx_sink.sv
`timescale 1ns/1ps
// receiver stand-in: only paces the frame handshake, lanes come from lane_0 upward
module tsm_rx_sink (
  input wire logic clk_i,
  input wire logic [1:0] pace_i,
  output logic ready_o
);
  logic [1:0] cnt_q = 2'h0;
  initial ready_o = 1'b0;
  // pace 0 prompt, 1 one cycle in four, 2 stalled
  always @(negedge clk_i) begin
    cnt_q <= cnt_q + 2'h1;
    ready_o <= (pace_i == 2'h0) || (pace_i == 2'h1 && cnt_q == 2'h0);
  end
endmodule

// File: tb/test_transport_sample_mapper_9bit.sv
`timescale 1ns/1ps
`include "tsm_cfg.svh"
module test_transport_sample_mapper_9bit;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [`TSM_MODE_W-1:0] mode = `TSM_MODE_8LANE;
  logic [1:0] part = `TSM_PART_QUAD;
  logic samp_valid_i = 1'b0;
  logic samp_ready_o, lane_valid_o, lane_ready_i, mode_err_o;
  logic [`TSM_CH_W-1:0] s [4];
  logic [`TSM_LANE_W-1:0] lo [8];
  logic [`TSM_LANES-1:0] lane_en_o;
  logic [1:0] pace = 2'h0;
  logic [519:0] expq [$];
  logic [519:0] e;
  logic [17:0] aq [$];
  bit tk = 1'b0;
  integer seed = 74;
  int num_errors = 0;
  int checks_done = 0;
  int acc = 0;

  always #5 clk_i = ~clk_i;

  tsm_mapper dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .link_mode_select_i(mode), .part_cfg_i(part),
    .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o), .samp_a_i(s[0]), .samp_b_i(s[1]),
    .samp_c_i(s[2]), .samp_d_i(s[3]), .lane_valid_o(lane_valid_o), .lane_ready_i(lane_ready_i),
    .lane_0_o(lo[0]), .lane_1_o(lo[1]), .lane_2_o(lo[2]), .lane_3_o(lo[3]), .lane_4_o(lo[4]),
    .lane_5_o(lo[5]), .lane_6_o(lo[6]), .lane_7_o(lo[7]), .lane_en_o(lane_en_o), .mode_err_o(mode_err_o));
  tsm_rx_sink rx (.clk_i(clk_i), .pace_i(pace), .ready_o(lane_ready_i));

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // reference packing worked out from sample index and part width
  function automatic logic [519:0] frame(input logic [3:0] m, input logic [1:0] p);
    logic [63:0] l [8];
    logic [89:0] x, y;
    logic [7:0] en;
    int nch;
    nch = (p == 2'h1) ? 2 : (p == 2'h2) ? 4 : 1;
    for (int i = 0; i < 8; i++) l[i] = 64'h0;
    if (m == `TSM_MODE_8LANE) begin
      en = (nch == 4) ? 8'hFF : (nch == 2) ? 8'h0F : 8'h03;
      for (int c = 0; c < nch; c++)
        for (int q = 0; q < 2; q++)
          for (int j = 0; j < 5; j++) l[2*c+q][63-12*j -: 12] = {s[c][9*(2*j+q) +: 9], 3'h0};
    end else begin
      en = (nch == 4) ? 8'h3F : (nch == 2) ? 8'h07 : 8'h03;
      for (int g = 0; g < ((nch == 4) ? 2 : 1); g++) begin
        x = s[2*g];
        y = s[2*g+1];
        l[3*g][63:48] = {x[8:0], 3'h0, x[17:14]};
        l[3*g+1][63:48] = {x[13:9], 3'h0, (nch > 1) ? y[8:1] : 8'h00};
        if (nch > 1) l[3*g+2][63:48] = {y[0], 3'h0, y[17:9], 3'h0};
      end
    end
    return {en, l[7], l[6], l[5], l[4], l[3], l[2], l[1], l[0]};
  endfunction

  // one cycle: a pending request is held until taken
  task automatic cyc(input bit push, input bit cer);
    @(negedge clk_i);
    ce_i = cer ? ($random(seed) % 5 != 0) : 1'b1;
    // a frame taken at the last rising edge is replaced or released only now
    if (push && (tk || !samp_valid_i)) begin
      for (int c = 0; c < 4; c++) s[c] = 90'({$random(seed), $random(seed), $random(seed)});
      samp_valid_i = 1'b1;
    end else if (tk) begin
      samp_valid_i = 1'b0;
    end
    tk = 1'b0;
    #1;
    if (lane_valid_o === 1'b1 && lane_ready_i && ce_i) begin
      if (expq.size() == 0) chk(64'h1, 64'h0);
      else begin
        e = expq.pop_front();
        for (int i = 0; i < 8; i++) chk(lo[i], e[64*i +: 64]);
        chk(lo[0][3:0], 64'h0);
        chk(lane_en_o, e[519:512]);
        if (mode == `TSM_MODE_8LANE) chk(64'({lo[1][63:55], lo[0][63:55]}), 64'(aq.pop_front()));
        else chk(64'({lo[0][51:48], lo[1][63:59], lo[0][63:55]}), 64'(aq.pop_front()));
      end
    end
    if (samp_valid_i && samp_ready_o === 1'b1) begin
      acc++;
      tk = 1'b1;
      if (mode <= `TSM_MODE_6LANE) begin
        expq.push_back(frame(mode, part));
        aq.push_back(s[0][17:0]);
      end
    end
  endtask

  initial begin
    for (int c = 0; c < 4; c++) s[c] = '0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    for (int m = 0; m < 2; m++)
      for (int p = 0; p < 4; p++) begin
        @(negedge clk_i);
        mode = m[3:0];
        part = p[1:0];
        repeat (6) cyc(0, 0);
        chk(mode_err_o, 64'h0);
        // receiver stalled: fifo and output stage fill, then refuse
        pace = 2'h2;
        acc = 0;
        repeat (12) cyc(1, 0);
        chk(acc, 64'd5);
        pace = 2'h1;
        repeat (60) cyc($random(seed) % 2 != 0, 1);
        pace = 2'h0;
        for (int k = 0; k < 80 && (expq.size() > 0 || samp_valid_i); k++) cyc(0, 0);
        if (expq.size() > 0 || samp_valid_i) begin
          chk(64'h1, 64'h0);
          wrap_up();
        end
      end
    // unsupported mode: frame dropped, flag raised
    @(negedge clk_i);
    mode = 4'h2;
    repeat (6) cyc(0, 0);
    cyc(1, 0);
    repeat (6) cyc(0, 0);
    chk(mode_err_o, 64'h1);
    chk(lane_valid_o, 64'h0);
    wrap_up();
  end
endmodule
